// [hw/aab_consts.vh]
// Purpose: Shared constants for the execution datapath (operations, flag positions, cycle counts)
// Assumes: Included by bare name from every design file of the block
// Notes:   Definitions only, guarded against double inclusion
`ifndef AAB_CONSTS_VH
`define AAB_CONSTS_VH

// Operation codes from the decoder (6 bits)
`define AAB_OP_NOP        6'h00
`define AAB_OP_ADD        6'h01
`define AAB_OP_ADC        6'h02
`define AAB_OP_SUB        6'h03
`define AAB_OP_SUBTRACT_WITH_BORROW 6'h04
`define AAB_OP_SUBTRACT_IMMEDIATE 6'h05
`define AAB_OP_SUBTRACT_IMMEDIATE_WITH_BORROW 6'h06
`define AAB_OP_AND        6'h07
`define AAB_OP_OR         6'h08
`define AAB_OP_XOR        6'h09
`define AAB_OP_CLEAR_BITS_BY_MASK 6'h0A
`define AAB_OP_SET_BITS_BY_MASK 6'h0B
`define AAB_OP_ZERO_OR_MINUS_TEST 6'h0C
`define AAB_OP_ONES_COMPLEMENT 6'h0D
`define AAB_OP_TWOS_COMPLEMENT 6'h0E
`define AAB_OP_COMPARE_IMMEDIATE 6'h0F
`define AAB_OP_WORD_ADD_IMMEDIATE 6'h10
`define AAB_OP_WORD_SUBTRACT_IMMEDIATE 6'h11
`define AAB_OP_INDIRECT_JUMP 6'h12
`define AAB_OP_INDIRECT_CALL 6'h13
`define AAB_OP_RET        6'h14
`define AAB_OP_INTERRUPT_RETURN 6'h15
`define AAB_OP_COMPARE_SKIP_EQUAL 6'h16
`define AAB_OP_SKRB       6'h17
`define AAB_OP_SKPB       6'h18
`define AAB_OP_BRANCH_STATUS_BIT_SET 6'h19
`define AAB_OP_BRBC       6'h1A

// Status flag bit positions
`define AAB_FLAG_C        3'd0
`define AAB_FLAG_Z        3'd1
`define AAB_FLAG_N        3'd2
`define AAB_FLAG_V        3'd3
`define AAB_FLAG_S        3'd4
`define AAB_FLAG_H        3'd5
`define AAB_FLAG_T        3'd6
`define AAB_FLAG_I        3'd7

// Reset values
`define AAB_FLAGS_RST     8'h00
`define AAB_PC_RST        16'h0000

// Cycle counts
`define AAB_CYC_WORD      3'd2
`define AAB_CYC_INDIRECT_JUMP 3'd2
`define AAB_CYC_INDIRECT_CALL 3'd3
`define AAB_CYC_RET       3'd4
`define AAB_CYC_BR_TAKEN  3'd2

`endif

// [hw/aab_sync2.v]
// Purpose: Two-flop synchroniser for one level from outside the clock domain
// Assumes: Single clock, active-low asynchronous reset
// Notes:   First flop feeds only the second flop
`include "aab_consts.vh"
module aab_sync2
(
    // Clock and reset
    input  wire i_clk,
    input  wire i_rst_b,
    // Level in and out
    input  wire i_lvl,
    output wire o_lvl
);
    reg meta_ff;   // First stage, read by second only
    reg sync_ff;   // Safe stage

    // Two stages, constant under reset
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= i_lvl;
            sync_ff <= meta_ff;
        end
    end

    assign o_lvl = sync_ff;
endmodule // aab_sync2

// [hw/aab_addsub8.v]
// Purpose: 8-bit adder/subtractor with carry, half-carry and overflow
// Assumes: Pure combinational, used by the main datapath
// Notes:   Subtract returns borrow in carry out
`include "aab_consts.vh"
module aab_addsub8
(
    // Operands
    input  wire [7:0] i_a,
    input  wire [7:0] i_b,
    input  wire       i_cin,
    input  wire       i_sub,
    // Results
    output wire [7:0] o_res,
    output wire       o_c,
    output wire       o_h,
    output wire       o_v
);
    wire [7:0] b_eff;   // Inverted for subtract
    wire [8:0] sum;     // Full sum with carry
    wire [4:0] low;     // Low nibble sum for half carry
    wire       cin_eff; // Carry in, inverted for borrow

    assign b_eff   = i_sub ? ~i_b : i_b;
    assign cin_eff = i_sub ? ~i_cin : i_cin;
    assign sum     = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, cin_eff};
    assign low     = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    assign o_res   = sum[7:0];
    // Borrow is the inverse of carry when subtracting
    assign o_c     = i_sub ? ~sum[8] : sum[8];
    assign o_h     = i_sub ? ~low[4] : low[4];
    assign o_v     = (i_a[7] == b_eff[7]) && (sum[7] != i_a[7]);
endmodule // aab_addsub8

// [hw/aab_core.v]
// Purpose: Execution datapath: ALU, status flags and program-counter control
// Assumes: Decoder gives one op pulse per instruction with operands; register file writes back
// Notes:   Multi-cycle ops hold o_busy; decoder issues nothing while busy
`include "aab_consts.vh"

// Functional notes
// - Add, add-with-carry: one cycle, ZCNVH
// - Word add immediate: two cycles, ZCNVS
// - Subtract, with borrow: one cycle, ZCNVH
// - Subtract immediate, with borrow: one cycle
// - Word subtract immediate: two cycles, ZCNVS
// - AND, OR, XOR: ZNV, carry kept
// - Clear-mask ANDs complement; set-mask ORs
// - Zero-or-minus test: AND self, ZNV
// - Indirect jump: PC from pointer, two cycles
// - Indirect call: pointer target, three cycles
// - Compare-skip-equal skips next on match
// - Compare immediate: flags only, no store
// - Skip on register bit clear/set
// - Skip on port bit clear/set
// - Branch on status bit: taken two cycles
// - Signed branches use N xor V
// - Unsigned branches use carry flag
// - Half-carry branches test H
// - Transfer-bit branches test T
// - Interrupt-state branches test I
// - Overflow-clear branch taken when V zero
module aab_core
(
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_b,
    // Decoder request
    input  wire        i_op_valid,
    input  wire [5:0]  i_op,
    input  wire [7:0]  i_rd,
    input  wire [7:0]  i_rr,
    input  wire [7:0]  i_rd_hi,
    input  wire [7:0]  i_imm,
    input  wire [2:0]  i_bit_sel,
    input  wire [11:0] i_offset,
    input  wire        i_next_is_two_word,
    input  wire [15:0] i_pointer,
    input  wire [15:0] i_stack_pc,
    input  wire        i_port_bit,
    // Register file write-back
    output reg         o_wr_en,
    output reg         o_wr_pair,
    output reg  [7:0]  o_wr_lo,
    output reg  [7:0]  o_wr_hi,
    // Stack and status
    output wire        o_push_pc,
    output wire [15:0] o_ret_addr,
    output wire        o_busy,
    output wire [7:0]  o_flags,
    output wire [15:0] o_pc
);
    // One-hot states
    localparam [3:0] ST_IDLE = 4'b0001; // Ready for a new op
    localparam [3:0] ST_WAIT = 4'b0010; // Burning extra cycles
    localparam [3:0] ST_WORD = 4'b0100; // Second half of word op
    localparam [3:0] ST_SKIP = 4'b1000; // Skipping next instruction

    reg  [3:0]  state_ff;       // Control state
    reg  [3:0]  nxt_state;
    reg  [7:0]  flags_ff;       // Status flags register
    reg  [7:0]  nxt_flags;
    reg  [15:0] pc_ff;          // Program counter
    reg  [15:0] nxt_pc;
    reg  [2:0]  cnt_ff;         // Remaining wait cycles
    reg  [2:0]  nxt_cnt;
    reg  [7:0]  hi_ff;          // Word op: high byte held
    reg  [7:0]  nxt_hi;
    reg         wsub_ff;        // Word op: subtract
    reg         nxt_wsub;
    reg         wcarry_ff;      // Word op: low-byte carry
    reg         nxt_wcarry;
    reg  [7:0]  wlo_ff;         // Word op: low result
    reg  [7:0]  nxt_wlo;
    reg         push_ff;        // Call pushes return address
    reg         nxt_push;
    reg  [15:0] ret_ff;         // Return address to push
    reg  [15:0] nxt_ret;

    wire        port_bit_s;     // Port bit after synchroniser
    // Adder inputs and outputs
    reg  [7:0]  add_a;
    reg  [7:0]  add_b;
    reg         add_cin;
    reg         add_sub;
    wire [7:0]  add_res;
    wire        add_c;
    wire        add_h;
    wire        add_v;

    // Port bit comes from an I/O pin domain
    aab_sync2 u_port_sync
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_lvl   (i_port_bit),
        .o_lvl   (port_bit_s)
    );

    aab_addsub8 u_alu
    (
        .i_a   (add_a),
        .i_b   (add_b),
        .i_cin (add_cin),
        .i_sub (add_sub),
        .o_res (add_res),
        .o_c   (add_c),
        .o_h   (add_h),
        .o_v   (add_v)
    );

    wire is_op   = i_op_valid && (state_ff == ST_IDLE);
    wire [15:0] pc_inc  = pc_ff + 16'h0001;
    wire [15:0] pc_rel  = pc_inc + {{4{i_offset[11]}}, i_offset};
    // Skip distance: one word or two for a long next instruction
    wire [15:0] pc_skip = pc_ff + (i_next_is_two_word ? 16'h0003 : 16'h0002);
    wire        sel_bit = flags_ff[i_bit_sel];
    // Second half of word op: high byte with low carry
    wire [8:0]  hi_sum  = wsub_ff ? ({1'b0, hi_ff} - {8'h00, wcarry_ff})
                                  : ({1'b0, hi_ff} + {8'h00, wcarry_ff});
    wire [7:0]  hi_res  = hi_sum[7:0];
    wire        hi_c    = hi_sum[8];

    // Adder operand select
    always @*
    begin
        add_a   = i_rd;
        add_b   = i_rr;
        add_cin = 1'b0;
        add_sub = 1'b0;
        case (i_op)
            `AAB_OP_ADC:  add_cin = flags_ff[`AAB_FLAG_C];
            `AAB_OP_SUB:  add_sub = 1'b1;
            `AAB_OP_SUBTRACT_WITH_BORROW:
            begin
                add_sub = 1'b1;
                add_cin = flags_ff[`AAB_FLAG_C];
            end
            `AAB_OP_SUBTRACT_IMMEDIATE, `AAB_OP_COMPARE_IMMEDIATE:
            begin
                add_sub = 1'b1;
                add_b   = i_imm;
            end
            `AAB_OP_SUBTRACT_IMMEDIATE_WITH_BORROW:
            begin
                add_sub = 1'b1;
                add_b   = i_imm;
                add_cin = flags_ff[`AAB_FLAG_C];
            end
            `AAB_OP_ONES_COMPLEMENT:
            begin
                add_sub = 1'b1;
                add_a   = 8'hFF;
                add_b   = i_rd;
            end
            `AAB_OP_TWOS_COMPLEMENT:
            begin
                add_sub = 1'b1;
                add_a   = 8'h00;
                add_b   = i_rd;
            end
            `AAB_OP_WORD_ADD_IMMEDIATE: add_b = i_imm;
            `AAB_OP_WORD_SUBTRACT_IMMEDIATE:
            begin
                add_sub = 1'b1;
                add_b   = i_imm;
            end
            default:      add_sub = 1'b0;
        endcase
    end

    // Main next-state logic
    always @*
    begin : nxt_logic
        reg [7:0] lres;   // Logic result
        reg       cond;   // Branch or skip condition
        lres       = 8'h00;
        cond       = 1'b0;
        nxt_state  = state_ff;
        nxt_flags  = flags_ff;
        nxt_pc     = pc_ff;
        nxt_cnt    = cnt_ff;
        nxt_hi     = hi_ff;
        nxt_wsub   = wsub_ff;
        nxt_wcarry = wcarry_ff;
        nxt_wlo    = wlo_ff;
        nxt_push   = 1'b0;
        nxt_ret    = ret_ff;
        o_wr_en    = 1'b0;
        o_wr_pair  = 1'b0;
        o_wr_lo    = 8'h00;
        o_wr_hi    = 8'h00;
        case (state_ff)
            ST_IDLE:
            begin
                if (is_op)
                begin
                    nxt_pc = pc_inc;
                    case (i_op)
                        `AAB_OP_ADD, `AAB_OP_ADC, `AAB_OP_SUB, `AAB_OP_SUBTRACT_WITH_BORROW,
                        `AAB_OP_SUBTRACT_IMMEDIATE, `AAB_OP_SUBTRACT_IMMEDIATE_WITH_BORROW, `AAB_OP_TWOS_COMPLEMENT,
                        `AAB_OP_COMPARE_IMMEDIATE:
                        begin
                            // Arithmetic: ZCNVH in one cycle
                            nxt_flags[`AAB_FLAG_Z] = (add_res == 8'h00);
                            nxt_flags[`AAB_FLAG_C] = add_c;
                            nxt_flags[`AAB_FLAG_N] = add_res[7];
                            nxt_flags[`AAB_FLAG_V] = add_v;
                            nxt_flags[`AAB_FLAG_H] = add_h;
                            o_wr_en = (i_op != `AAB_OP_COMPARE_IMMEDIATE);
                            o_wr_lo = add_res;
                        end
                        `AAB_OP_ONES_COMPLEMENT:
                        begin
                            // Carry always set; H untouched
                            nxt_flags[`AAB_FLAG_Z] = (add_res == 8'h00);
                            nxt_flags[`AAB_FLAG_C] = 1'b1;
                            nxt_flags[`AAB_FLAG_N] = add_res[7];
                            nxt_flags[`AAB_FLAG_V] = 1'b0;
                            o_wr_en = 1'b1;
                            o_wr_lo = add_res;
                        end
                        `AAB_OP_AND, `AAB_OP_OR, `AAB_OP_XOR, `AAB_OP_CLEAR_BITS_BY_MASK,
                        `AAB_OP_SET_BITS_BY_MASK, `AAB_OP_ZERO_OR_MINUS_TEST:
                        begin
                            case (i_op)
                                `AAB_OP_AND: lres = i_rd & i_rr;
                                `AAB_OP_OR:  lres = i_rd | i_rr;
                                `AAB_OP_XOR: lres = i_rd ^ i_rr;
                                `AAB_OP_CLEAR_BITS_BY_MASK: lres = i_rd & ~i_imm;
                                `AAB_OP_SET_BITS_BY_MASK: lres = i_rd | i_imm;
                                default:     lres = i_rd & i_rd;
                            endcase
                            // Carry left alone; V cleared by logic ops
                            nxt_flags[`AAB_FLAG_Z] = (lres == 8'h00);
                            nxt_flags[`AAB_FLAG_N] = lres[7];
                            nxt_flags[`AAB_FLAG_V] = 1'b0;
                            o_wr_en = 1'b1;
                            o_wr_lo = lres;
                        end
                        `AAB_OP_WORD_ADD_IMMEDIATE, `AAB_OP_WORD_SUBTRACT_IMMEDIATE:
                        begin
                            // Low byte now, high byte next cycle
                            nxt_wlo    = add_res;
                            nxt_wcarry = add_c;
                            nxt_wsub   = (i_op == `AAB_OP_WORD_SUBTRACT_IMMEDIATE);
                            nxt_hi     = i_rd_hi;
                            nxt_state  = ST_WORD;
                        end
                        `AAB_OP_INDIRECT_JUMP:
                        begin
                            nxt_pc    = i_pointer;
                            nxt_cnt   = `AAB_CYC_INDIRECT_JUMP - 3'd1;
                            nxt_state = ST_WAIT;
                        end
                        `AAB_OP_INDIRECT_CALL:
                        begin
                            nxt_pc    = i_pointer;
                            nxt_ret   = pc_inc;
                            nxt_push  = 1'b1;
                            nxt_cnt   = `AAB_CYC_INDIRECT_CALL - 3'd1;
                            nxt_state = ST_WAIT;
                        end
                        `AAB_OP_RET, `AAB_OP_INTERRUPT_RETURN:
                        begin
                            nxt_pc    = i_stack_pc;
                            nxt_cnt   = `AAB_CYC_RET - 3'd1;
                            nxt_state = ST_WAIT;
                            if (i_op == `AAB_OP_INTERRUPT_RETURN)
                                nxt_flags[`AAB_FLAG_I] = 1'b1;
                        end
                        `AAB_OP_COMPARE_SKIP_EQUAL, `AAB_OP_SKRB, `AAB_OP_SKPB:
                        begin
                            // i_bit_sel[0]-free polarity: imm[0] picks set variant
                            if (i_op == `AAB_OP_COMPARE_SKIP_EQUAL)
                                cond = (i_rd == i_rr);
                            else if (i_op == `AAB_OP_SKRB)
                                cond = (i_rr[i_bit_sel] == i_imm[0]);
                            else
                                cond = (port_bit_s == i_imm[0]);
                            if (cond)
                            begin
                                nxt_pc    = pc_skip;
                                nxt_cnt   = i_next_is_two_word ? 3'd2 : 3'd1;
                                nxt_state = ST_SKIP;
                            end
                        end
                        `AAB_OP_BRANCH_STATUS_BIT_SET, `AAB_OP_BRBC:
                        begin
                            // Named branches map onto a status bit and polarity:
                            // signed uses S (N xor V), unsigned uses C, V-clear tests V=0
                            cond = (i_op == `AAB_OP_BRANCH_STATUS_BIT_SET) ? sel_bit : ~sel_bit;
                            if (cond)
                            begin
                                nxt_pc    = pc_rel;
                                nxt_cnt   = `AAB_CYC_BR_TAKEN - 3'd1;
                                nxt_state = ST_WAIT;
                            end
                        end
                        default: nxt_pc = pc_inc;
                    endcase
                    // Signed flag follows N xor V for every flag-writing op
                    nxt_flags[`AAB_FLAG_S] = nxt_flags[`AAB_FLAG_N] ^ nxt_flags[`AAB_FLAG_V];
                end
            end
            ST_WORD:
            begin
                // High byte done: write pair, set ZCNVS
                o_wr_en   = 1'b1;
                o_wr_pair = 1'b1;
                o_wr_lo   = wlo_ff;
                o_wr_hi   = hi_res;
                nxt_flags[`AAB_FLAG_Z] = ({hi_res, wlo_ff} == 16'h0000);
                nxt_flags[`AAB_FLAG_C] = hi_c;
                nxt_flags[`AAB_FLAG_N] = hi_res[7];
                nxt_flags[`AAB_FLAG_V] = wsub_ff ? (hi_ff[7] & ~hi_res[7]) : (~hi_ff[7] & hi_res[7]);
                nxt_flags[`AAB_FLAG_S] = hi_res[7] ^ nxt_flags[`AAB_FLAG_V];
                nxt_state = ST_IDLE;
            end
            ST_WAIT, ST_SKIP:
            begin
                // Extra cycles of a multi-cycle op
                nxt_cnt = cnt_ff - 3'd1;
                if (cnt_ff == 3'd1)
                    nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // State registers
    always @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_ff  <= ST_IDLE;
            flags_ff  <= `AAB_FLAGS_RST;
            pc_ff     <= `AAB_PC_RST;
            cnt_ff    <= 3'd0;
            hi_ff     <= 8'h00;
            wsub_ff   <= 1'b0;
            wcarry_ff <= 1'b0;
            wlo_ff    <= 8'h00;
            push_ff   <= 1'b0;
            ret_ff    <= 16'h0000;
        end
        else
        begin
            state_ff  <= nxt_state;
            flags_ff  <= nxt_flags;
            pc_ff     <= nxt_pc;
            cnt_ff    <= nxt_cnt;
            hi_ff     <= nxt_hi;
            wsub_ff   <= nxt_wsub;
            wcarry_ff <= nxt_wcarry;
            wlo_ff    <= nxt_wlo;
            push_ff   <= nxt_push;
            ret_ff    <= nxt_ret;
        end
    end

    assign o_push_pc  = push_ff;
    assign o_ret_addr = ret_ff;
    assign o_busy     = (state_ff != ST_IDLE);
    assign o_flags    = flags_ff;
    assign o_pc       = pc_ff;
endmodule // aab_core

// [verification/aab_rf_model.sv]
// Purpose: Register-file side model that keeps the last write-back
// Assumes: Write-back arrives as one-cycle pulses from the core
// Notes:   Pair writes store both bytes; single writes clear the high byte
module aab_rf_model
(
    // Clock
    input  wire         i_clk,
    // Write-back from the core
    input  wire         i_wr_en,
    input  wire         i_wr_pair,
    input  wire  [7:0]  i_wr_lo,
    input  wire  [7:0]  i_wr_hi,
    // Last stored value
    output logic [15:0] o_last
);
    timeunit 1ns;
    timeprecision 1ns;
    // Capture on the write edge, like a real register file
    always @(posedge i_clk)
    begin
        if (i_wr_en)
        begin
            o_last <= i_wr_pair ? {i_wr_hi, i_wr_lo} : {8'h00, i_wr_lo};
        end
    end
endmodule // aab_rf_model

// [verification/aab_core_monitor.sv]
// Purpose: Timing and value checks on the core ports
// Assumes: One clock, active-low asynchronous reset
// Notes:   Checks hold only while out of reset
`include "aab_consts.vh"
module aab_core_monitor
(
    input wire        i_clk,
    input wire        i_rst_b,
    input wire        i_op_valid,
    input wire [5:0]  i_op,
    input wire [7:0]  i_rd,
    input wire [7:0]  i_rr,
    input wire [7:0]  i_imm,
    input wire [2:0]  i_bit_sel,
    input wire        o_wr_en,
    input wire [7:0]  o_wr_lo,
    input wire        o_busy,
    input wire [7:0]  o_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Request accepted on this edge
    wire tk = i_op_valid && !o_busy;
    add_sum_a: assert property (tk && i_op == `AAB_OP_ADD |-> o_wr_en && o_wr_lo == i_rd + i_rr)
        else $error("add result wrong");
    subtract_immediate_diff_a: assert property (tk && i_op == `AAB_OP_SUBTRACT_IMMEDIATE |-> o_wr_lo == i_rd - i_imm)
        else $error("subtract immediate result wrong");
    word_two_cyc_a: assert property (tk && (i_op == `AAB_OP_WORD_ADD_IMMEDIATE ||
        i_op == `AAB_OP_WORD_SUBTRACT_IMMEDIATE) |=> o_busy ##1 !o_busy)
        else $error("word op length wrong");
    logic_carry_a: assert property (tk && (i_op == `AAB_OP_AND || i_op == `AAB_OP_OR ||
        i_op == `AAB_OP_XOR) |=> o_flags[0] == $past(o_flags[0])) else $error("logic op changed carry");
    clear_mask_a: assert property (tk && i_op == `AAB_OP_CLEAR_BITS_BY_MASK |-> o_wr_lo == (i_rd & ~i_imm))
        else $error("mask clear wrong");
    test_keep_a: assert property (tk && i_op == `AAB_OP_ZERO_OR_MINUS_TEST |-> !o_wr_en || o_wr_lo == i_rd)
        else $error("test altered register");
    cpi_nostore_a: assert property (tk && i_op == `AAB_OP_COMPARE_IMMEDIATE |-> !o_wr_en)
        else $error("compare stored a result");
    branch_cyc_a: assert property (tk && i_op == `AAB_OP_BRANCH_STATUS_BIT_SET && o_flags[i_bit_sel]
        |=> o_busy ##1 !o_busy) else $error("taken branch length wrong");
    cover property (tk && i_op == `AAB_OP_WORD_ADD_IMMEDIATE);
    cover property (tk && i_op == `AAB_OP_COMPARE_IMMEDIATE);
    cover property (tk && i_op == `AAB_OP_BRBC);
endmodule // aab_core_monitor
bind aab_core aab_core_monitor u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_rd(i_rd), .i_rr(i_rr), .i_imm(i_imm), .i_bit_sel(i_bit_sel), .o_wr_en(o_wr_en), .o_wr_lo(o_wr_lo),
    .o_busy(o_busy), .o_flags(o_flags));

// [verification/testbench.sv]
// Purpose: Self-checking bench for the execution datapath
// Assumes: 20 MHz clock, reset held three cycles
// Notes:   Table of one-cycle ops, then word ops, branches and reset
`include "aab_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [5:0] op; logic [7:0] rd, rr, imm, res, flg, msk;} aab_row_t;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_op_valid = 1'b0;
    logic [5:0]  i_op = 6'h00;
    logic [7:0]  i_rd = 8'h00, i_rr = 8'h00, i_rd_hi = 8'h00, i_imm = 8'h00;
    logic [2:0]  i_bit_sel = 3'h0;
    logic        i_port_bit = 1'b1;
    logic        o_wr_en, o_wr_pair, o_busy, o_push_pc;
    logic [7:0]  o_wr_lo, o_wr_hi, o_flags;
    logic [15:0] o_ret_addr, o_pc, base, rf_last;
    int          n_errors = 0, total_checks = 0, cycles = 0;
    // Op, rd, rr, imm, result, flags, flag mask; carry chains row to row
    aab_row_t rows [14] = '{
        '{`AAB_OP_ADD, 8'h0F, 8'h01, 8'h00, 8'h10, 8'h20, 8'h2F}, '{`AAB_OP_ADD, 8'h80, 8'h80, 8'h00, 8'h00, 8'h0B, 8'h2F},
        '{`AAB_OP_AND, 8'hF0, 8'h8F, 8'h00, 8'h80, 8'h05, 8'h0F}, '{`AAB_OP_ADC, 8'h01, 8'h01, 8'h00, 8'h03, 8'h00, 8'h2F},
        '{`AAB_OP_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h25, 8'h2F},
        '{`AAB_OP_SUBTRACT_WITH_BORROW, 8'h05, 8'h02, 8'h00, 8'h02, 8'h00, 8'h2F},
        '{`AAB_OP_SUBTRACT_IMMEDIATE, 8'h80, 8'h00, 8'h01, 8'h7F, 8'h28, 8'h2F},
        '{`AAB_OP_OR, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0F}, '{`AAB_OP_XOR, 8'hFF, 8'h0F, 8'h00, 8'hF0, 8'h04, 8'h0F},
        '{`AAB_OP_CLEAR_BITS_BY_MASK, 8'hFF, 8'h00, 8'h0F, 8'hF0, 8'h04, 8'h0E},
        '{`AAB_OP_SET_BITS_BY_MASK, 8'h00, 8'h00, 8'h81, 8'h81, 8'h04, 8'h0E},
        '{`AAB_OP_TWOS_COMPLEMENT, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h25, 8'h2F},
        '{`AAB_OP_ONES_COMPLEMENT, 8'h0F, 8'h00, 8'h00, 8'hF0, 8'h05, 8'h0F},
        '{`AAB_OP_SUBTRACT_IMMEDIATE_WITH_BORROW, 8'h12, 8'h00, 8'h01, 8'h10, 8'h00, 8'h2F}};
    aab_core dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid), .i_op(i_op), .i_rd(i_rd), .i_rr(i_rr),
        .i_rd_hi(i_rd_hi), .i_imm(i_imm), .i_bit_sel(i_bit_sel), .i_offset(12'h010), .i_next_is_two_word(1'b0),
        .i_pointer(16'h0123), .i_stack_pc(16'h0456), .i_port_bit(i_port_bit), .o_wr_en(o_wr_en),
        .o_wr_pair(o_wr_pair), .o_wr_lo(o_wr_lo), .o_wr_hi(o_wr_hi), .o_push_pc(o_push_pc), .o_ret_addr(o_ret_addr),
        .o_busy(o_busy),
        .o_flags(o_flags), .o_pc(o_pc));
    aab_rf_model u_rf (.i_clk(i_clk), .i_wr_en(o_wr_en), .i_wr_pair(o_wr_pair), .i_wr_lo(o_wr_lo),
        .i_wr_hi(o_wr_hi), .o_last(rf_last));
    // 50 ns period
    always #25 i_clk = ~i_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Request held from one rising edge to the next; outputs read mid-cycle
    task automatic issue(input logic [5:0] op, input logic [7:0] rd, rr, imm);
        @(posedge i_clk);
        i_op_valid <= 1'b1;
        i_op <= op;
        i_rd <= rd;
        i_rr <= rr;
        i_imm <= imm;
        @(negedge i_clk);
    endtask
    task automatic idle;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        @(negedge i_clk);
    endtask
    task automatic word(input logic [5:0] op, input logic [7:0] lo, hi, k, flg, input logic [15:0] res);
        @(posedge i_clk);
        i_rd_hi <= hi;
        issue(op, lo, 8'h00, k);
        idle;
        chk(o_busy, 1'b1);
        idle;
        chk(o_busy, 1'b0);
        chk(rf_last, res);
        chk(o_flags & 8'h1F, flg);
    endtask
    // Offset is 16, so a taken branch lands 17 words on
    task automatic branch(input logic [5:0] op, input logic [2:0] sel, input logic taken);
        @(posedge i_clk);
        i_bit_sel <= sel;
        @(negedge i_clk);
        base = o_pc;
        issue(op, 8'h00, 8'h00, 8'h00);
        idle;
        chk(o_pc, base + (taken ? 16'h0011 : 16'h0001));
        chk(o_busy, taken);
        idle;
    endtask
    // Taken skip: pc moves two words on, one extra busy cycle
    task automatic skip(input logic [5:0] op, input logic [7:0] rd, rr, imm, input logic [15:0] pc);
        issue(op, rd, rr, imm);
        idle;
        chk(o_pc, pc);
        chk(o_busy, 1'b1);
        idle;
    endtask
    // Hang guard well above the fewer than 100 cycles needed
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        foreach (rows[i])
        begin
            issue(rows[i].op, rows[i].rd, rows[i].rr, rows[i].imm);
            chk(o_wr_en, 1'b1);
            chk(o_wr_lo, rows[i].res);
            if (i > 0)
                chk(o_flags & rows[i - 1].msk, rows[i - 1].flg);
        end
        issue(`AAB_OP_ZERO_OR_MINUS_TEST, 8'h80, 8'h00, 8'h00);
        chk(o_flags & 8'h2F, 8'h00);
        issue(`AAB_OP_COMPARE_IMMEDIATE, 8'h05, 8'h00, 8'h05);
        chk(o_wr_en, 1'b0);
        chk(o_flags & 8'h0E, 8'h04);
        idle;
        chk(o_flags & 8'h2F, 8'h02);
        word(`AAB_OP_WORD_ADD_IMMEDIATE, 8'hFF, 8'hFF, 8'h01, 8'h03, 16'h0000);
        word(`AAB_OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'h15, 16'hFFFF);
        branch(`AAB_OP_BRANCH_STATUS_BIT_SET, `AAB_FLAG_C, 1'b1);
        branch(`AAB_OP_BRBC, `AAB_FLAG_C, 1'b0);
        branch(`AAB_OP_BRANCH_STATUS_BIT_SET, `AAB_FLAG_S, 1'b1);
        branch(`AAB_OP_BRBC, `AAB_FLAG_V, 1'b1);
        branch(`AAB_OP_BRANCH_STATUS_BIT_SET, `AAB_FLAG_T, 1'b0);
        branch(`AAB_OP_BRBC, `AAB_FLAG_I, 1'b1);
        issue(`AAB_OP_INDIRECT_JUMP, 8'h00, 8'h00, 8'h00);
        idle;
        chk(o_pc, 16'h0123);
        chk(o_busy, 1'b1);
        issue(`AAB_OP_INDIRECT_CALL, 8'h00, 8'h00, 8'h00);
        chk(o_busy, 1'b0);
        chk(o_flags, 8'h15);
        idle;
        chk(o_push_pc, 1'b1);
        chk(o_ret_addr, 16'h0124);
        idle;
        chk(o_busy, 1'b1);
        issue(`AAB_OP_INTERRUPT_RETURN, 8'h00, 8'h00, 8'h00);
        chk(o_busy, 1'b0);
        idle;
        chk(o_pc, 16'h0456);
        chk(o_flags, 8'h95);
        repeat (2) idle;
        chk(o_busy, 1'b1);
        skip(`AAB_OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 8'h00, 16'h0458);
        skip(`AAB_OP_SKRB, 8'h00, 8'h80, 8'h01, 16'h045A);
        skip(`AAB_OP_SKPB, 8'h00, 8'h00, 8'h01, 16'h045C);
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        @(negedge i_clk);
        chk(o_flags, `AAB_FLAGS_RST);
        chk(o_pc, `AAB_PC_RST);
        wrap_up();
    end
endmodule // testbench
